// ### pkg/rtc_pkg.sv
// Constants, register map and carrier types of the time and calendar counter bank.
// Assumes a single 100 MHz system clock; all slower rates are enable pulses.
package rtc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ     = 100_000_000;
    localparam int unsigned TICK_PERIOD_S  = 1;
    localparam int unsigned TICK_CYCLES    = SYS_CLK_HZ * TICK_PERIOD_S;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SECONDS  = 8'h02;
    localparam logic [7:0] ADDR_MINUTES  = 8'h03;
    localparam logic [7:0] ADDR_HOURS    = 8'h04;
    localparam logic [7:0] ADDR_DAY      = 8'h05;
    localparam logic [7:0] ADDR_WEEKDAY  = 8'h06;
    localparam logic [7:0] ADDR_MONTH    = 8'h07;
    localparam logic [7:0] ADDR_YEAR     = 8'h08;

    // ------------------------------------------------------------
    // Field layout: writable bits of each register
    // ------------------------------------------------------------
    localparam int unsigned RESET_FLAG_BIT = 7;
    localparam int unsigned MERIDIEM_BIT   = 5;
    localparam logic [7:0] MASK_SECONDS   = 8'h7f;
    localparam logic [7:0] MASK_MINUTES   = 8'h7f;
    localparam logic [7:0] MASK_HOURS     = 8'h3f;
    localparam logic [7:0] MASK_HOURS_12  = 8'h1f;
    localparam logic [7:0] MASK_DAY       = 8'h3f;
    localparam logic [7:0] MASK_WEEKDAY   = 8'h07;
    localparam logic [7:0] MASK_MONTH     = 8'h1f;
    localparam logic [7:0] MASK_YEAR      = 8'hff;

    // ------------------------------------------------------------
    // Counter limits (BCD)
    // ------------------------------------------------------------
    localparam logic [7:0] MAX_SECONDS   = 8'h59;
    localparam logic [7:0] MAX_MINUTES   = 8'h59;
    localparam logic [7:0] MAX_HOURS_24  = 8'h23;
    localparam logic [7:0] MAX_HOURS_12  = 8'h12;
    localparam logic [7:0] HOUR_12_FLIP  = 8'h11;
    localparam logic [7:0] MAX_WEEKDAY   = 8'h06;
    localparam logic [7:0] MAX_MONTH     = 8'h12;
    localparam logic [7:0] MAX_YEAR      = 8'h99;
    localparam logic [7:0] MIN_ZERO      = 8'h00;
    localparam logic [7:0] MIN_ONE       = 8'h01;
    localparam logic [7:0] DAYS_31       = 8'h31;
    localparam logic [7:0] DAYS_30       = 8'h30;
    localparam logic [7:0] DAYS_29       = 8'h29;
    localparam logic [7:0] DAYS_28       = 8'h28;
    localparam logic [7:0] MONTH_FEB     = 8'h02;
    localparam logic [7:0] MONTH_APR     = 8'h04;
    localparam logic [7:0] MONTH_JUN     = 8'h06;
    localparam logic [7:0] MONTH_SEP     = 8'h09;
    localparam logic [7:0] MONTH_NOV     = 8'h11;
    localparam logic [2:0] WEEK_START    = 3'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SECONDS  = 8'h00;
    localparam logic [7:0] RST_MINUTES  = 8'h00;
    localparam logic [7:0] RST_HOURS    = 8'h00;
    localparam logic [7:0] RST_DAY      = 8'h01;
    localparam logic [7:0] RST_WEEKDAY  = 8'h00;
    localparam logic [7:0] RST_MONTH    = 8'h01;
    localparam logic [7:0] RST_YEAR     = 8'h00;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] year;
    } calendar_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ### src/bcd_step.sv
// One BCD counter step: increments a packed two-digit value or wraps it.
// Assumes the caller gives the current value and its inclusive maximum.
module bcd_step #(
    parameter logic [7:0] MIN_VAL = 8'h00
) (
    // Counter state
    input  wire logic [7:0] i_value,
    input  wire logic [7:0] i_max,
    input  wire logic       i_en,
    // Result
    output logic [7:0]      o_next,
    output logic            o_carry
);

    // Values at or above the limit wrap too, so a bad write cannot stall the chain
    always_comb begin
        o_carry = i_en && (i_value >= i_max);
        if (!i_en) begin
            o_next = i_value;
        end else if (i_value >= i_max) begin
            o_next = MIN_VAL;
        end else if (i_value[3:0] >= 4'h9) begin
            o_next = {i_value[7:4] + 4'h1, 4'h0};
        end else begin
            o_next = {i_value[7:4], i_value[3:0] + 4'h1};
        end
    end

endmodule

// ### src/rtc_calendar.sv
// Time of day and calendar counter bank with its register port.
// Assumes the serial front end presents single-cycle read and write strobes
// on the system clock, and the hour-format bit comes from same-clock logic.

module rtc_calendar #(
    parameter int unsigned TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                I_SYS_CLK,
    input  wire logic                I_NRST,
    // Configuration
    input  wire logic                I_HOUR_12,
    // Register port
    input  wire logic                I_REG_WR,
    input  wire logic                I_REG_RD,
    input  wire logic [7:0]          I_REG_ADDR,
    input  wire logic [7:0]          I_REG_WDATA,
    output logic [7:0]               O_REG_RDATA,
    // Status
    output rtc_pkg::calendar_t       O_TIME,
    output logic                     O_RESET_OCCURRED_FLAG,
    output logic                     O_SECOND_TICK,
    output logic                     O_NEW_WEEK
);

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    rtc_pkg::reg_req_t  req;
    rtc_pkg::calendar_t cal;
    rtc_pkg::calendar_t next_cal;
    logic [26:0]        div_cnt;
    logic [26:0]        next_div_cnt;
    logic               tick;
    logic               next_tick;
    logic               reset_occurred_flag;
    logic               next_reset_occurred_flag;
    logic               new_week;
    logic               next_new_week;
    logic [7:0]         rdata;
    logic [7:0]         next_rdata;
    logic [7:0]         sec_step;
    logic [7:0]         min_step;
    logic [7:0]         h24_step;
    logic [7:0]         h12_step;
    logic [7:0]         day_step;
    logic [7:0]         wday_step;
    logic [7:0]         month_step;
    logic [7:0]         year_step;
    logic               sec_carry;
    logic               min_carry;
    logic               h24_carry;
    logic               day_carry;
    logic               month_carry;
    logic               hour_carry;
    logic [7:0]         hour_adv;
    logic [7:0]         hour12_value;
    logic               meridiem_indicator;
    logic               leap_year;
    logic [7:0]         month_days;

    assign req = '{wr: I_REG_WR, rd: I_REG_RD, addr: I_REG_ADDR, wdata: I_REG_WDATA};
    assign hour12_value = cal.hours & rtc_pkg::MASK_HOURS_12;
    assign meridiem_indicator = cal.hours[rtc_pkg::MERIDIEM_BIT];

    // ------------------------------------------------------------
    // One second enable divider
    // ------------------------------------------------------------
    always_comb begin
        next_tick = 1'b0;
        if (div_cnt >= 27'(TICK_CYCLES - 1)) begin
            next_div_cnt = '0;
            next_tick    = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 27'h1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // Carry chain
    // ------------------------------------------------------------
    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ZERO)) u_sec (
        .i_value (cal.seconds),
        .i_max   (rtc_pkg::MAX_SECONDS),
        .i_en    (tick),
        .o_next  (sec_step),
        .o_carry (sec_carry)
    );

    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ZERO)) u_min (
        .i_value (cal.minutes),
        .i_max   (rtc_pkg::MAX_MINUTES),
        .i_en    (sec_carry),
        .o_next  (min_step),
        .o_carry (min_carry)
    );

    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ZERO)) u_h24 (
        .i_value (cal.hours),
        .i_max   (rtc_pkg::MAX_HOURS_24),
        .i_en    (min_carry && !I_HOUR_12),
        .o_next  (h24_step),
        .o_carry (h24_carry)
    );

    // In 12 hour mode the count runs 12, 01 .. 11; 12 wraps to 01
    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ONE)) u_h12 (
        .i_value (hour12_value),
        .i_max   (rtc_pkg::MAX_HOURS_12),
        .i_en    (min_carry && I_HOUR_12),
        .o_next  (h12_step),
        .o_carry ()
    );

    // Leap year: BCD year divisible by 4, year 00 included
    always_comb begin
        if (cal.year[4]) begin
            leap_year = (cal.year[3:0] == 4'h2) || (cal.year[3:0] == 4'h6);
        end else begin
            leap_year = (cal.year[3:0] == 4'h0) || (cal.year[3:0] == 4'h4) ||
                        (cal.year[3:0] == 4'h8);
        end
        if (cal.month == rtc_pkg::MONTH_FEB) begin
            month_days = leap_year ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
        end else if ((cal.month == rtc_pkg::MONTH_APR) || (cal.month == rtc_pkg::MONTH_JUN) ||
                     (cal.month == rtc_pkg::MONTH_SEP) || (cal.month == rtc_pkg::MONTH_NOV)) begin
            month_days = rtc_pkg::DAYS_30;
        end else begin
            month_days = rtc_pkg::DAYS_31;
        end
    end

    // Hour advance for either format
    always_comb begin
        if (I_HOUR_12) begin
            hour_adv   = {cal.hours[7:6], meridiem_indicator, h12_step[4:0]};
            hour_carry = 1'b0;
            if (min_carry && (hour12_value == rtc_pkg::HOUR_12_FLIP)) begin
                hour_adv[rtc_pkg::MERIDIEM_BIT] = !meridiem_indicator;
                hour_carry = meridiem_indicator;
            end
        end else begin
            hour_adv   = h24_step;
            hour_carry = h24_carry;
        end
    end

    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ONE)) u_day (
        .i_value (cal.day),
        .i_max   (month_days),
        .i_en    (hour_carry),
        .o_next  (day_step),
        .o_carry (day_carry)
    );

    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ZERO)) u_wday (
        .i_value (cal.weekday),
        .i_max   (rtc_pkg::MAX_WEEKDAY),
        .i_en    (hour_carry),
        .o_next  (wday_step),
        .o_carry ()
    );

    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ONE)) u_month (
        .i_value (cal.month),
        .i_max   (rtc_pkg::MAX_MONTH),
        .i_en    (day_carry),
        .o_next  (month_step),
        .o_carry (month_carry)
    );

    bcd_step #(.MIN_VAL(rtc_pkg::MIN_ZERO)) u_year (
        .i_value (cal.year),
        .i_max   (rtc_pkg::MAX_YEAR),
        .i_en    (month_carry),
        .o_next  (year_step),
        .o_carry ()
    );

    // ------------------------------------------------------------
    // Counter registers and register writes
    // ------------------------------------------------------------
    // A write beats the tick for the addressed register only; the others
    // still advance, so a write never costs the clock a second.
    always_comb begin
        next_cal = '{seconds: sec_step,   minutes: min_step,  hours: hour_adv,
                     day:     day_step,   weekday: wday_step,
                     month:   month_step, year:    year_step};
        next_reset_occurred_flag = reset_occurred_flag;
        next_new_week = hour_carry && (wday_step[2:0] == rtc_pkg::WEEK_START);
        if (req.wr) begin
            unique case (req.addr)
                rtc_pkg::ADDR_SECONDS: begin
                    next_cal.seconds = req.wdata & rtc_pkg::MASK_SECONDS;
                    // Writing 0 clears the flag, writing 1 leaves it as it is
                    next_reset_occurred_flag = reset_occurred_flag &&
                                               req.wdata[rtc_pkg::RESET_FLAG_BIT];
                end
                rtc_pkg::ADDR_MINUTES: next_cal.minutes = req.wdata & rtc_pkg::MASK_MINUTES;
                rtc_pkg::ADDR_HOURS:   next_cal.hours   = req.wdata & rtc_pkg::MASK_HOURS;
                rtc_pkg::ADDR_DAY:     next_cal.day     = req.wdata & rtc_pkg::MASK_DAY;
                rtc_pkg::ADDR_WEEKDAY: next_cal.weekday = req.wdata & rtc_pkg::MASK_WEEKDAY;
                rtc_pkg::ADDR_MONTH:   next_cal.month   = req.wdata & rtc_pkg::MASK_MONTH;
                rtc_pkg::ADDR_YEAR:    next_cal.year    = req.wdata & rtc_pkg::MASK_YEAR;
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            cal <= '{seconds: rtc_pkg::RST_SECONDS, minutes: rtc_pkg::RST_MINUTES,
                     hours:   rtc_pkg::RST_HOURS,   day:     rtc_pkg::RST_DAY,
                     weekday: rtc_pkg::RST_WEEKDAY, month:   rtc_pkg::RST_MONTH,
                     year:    rtc_pkg::RST_YEAR};
            reset_occurred_flag <= 1'b1;
            new_week            <= 1'b0;
        end else begin
            cal                 <= next_cal;
            reset_occurred_flag <= next_reset_occurred_flag;
            new_week            <= next_new_week;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = rdata;
        if (req.rd) begin
            unique case (req.addr)
                rtc_pkg::ADDR_SECONDS: next_rdata = {reset_occurred_flag, cal.seconds[6:0]};
                rtc_pkg::ADDR_MINUTES: next_rdata = cal.minutes;
                rtc_pkg::ADDR_HOURS:   next_rdata = cal.hours;
                rtc_pkg::ADDR_DAY:     next_rdata = cal.day;
                rtc_pkg::ADDR_WEEKDAY: next_rdata = cal.weekday;
                rtc_pkg::ADDR_MONTH:   next_rdata = cal.month;
                rtc_pkg::ADDR_YEAR:    next_rdata = cal.year;
                default:               next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign O_REG_RDATA           = rdata;
    assign O_TIME                = cal;
    assign O_RESET_OCCURRED_FLAG = reset_occurred_flag;
    assign O_SECOND_TICK         = tick;
    assign O_NEW_WEEK            = new_week;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_bcd_units_carry;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (min_carry && !I_REG_WR && !I_HOUR_12 && cal.hours[3:0] == 4'h9 && cal.hours < 8'h23)
        |=> (cal.hours[3:0] == 4'h0) && (cal.hours[5:4] == $past(cal.hours[5:4]) + 2'h1);
    endproperty
    a_bcd_units_carry: assert property (p_bcd_units_carry) else $error("BCD units did not carry");

    property p_flag_clear;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (I_REG_WR && I_REG_ADDR == 8'h02 && !I_REG_WDATA[7]) |=> !O_RESET_OCCURRED_FLAG ##1 !O_RESET_OCCURRED_FLAG;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Reset flag not cleared");

    property p_sec_wrap;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (tick && !I_REG_WR && cal.seconds == 8'h59)
        |=> (cal.seconds == 8'h00) && (cal.minutes != $past(cal.minutes));
    endproperty
    a_sec_wrap: assert property (p_sec_wrap) else $error("Seconds did not wrap into minutes");

    property p_min_wrap;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (sec_carry && !I_REG_WR && cal.minutes == 8'h59) |=> cal.minutes == 8'h00;
    endproperty
    a_min_wrap: assert property (p_min_wrap) else $error("Minutes did not wrap");

    property p_hour24_wrap;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (min_carry && !I_REG_WR && !I_HOUR_12 && cal.hours == 8'h23)
        |=> (cal.hours == 8'h00) && (cal.weekday != $past(cal.weekday));
    endproperty
    a_hour24_wrap: assert property (p_hour24_wrap) else $error("24 hour wrap failed");

    property p_hour12_flip;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (min_carry && !I_REG_WR && I_HOUR_12 && cal.hours[4:0] == 5'h11)
        |=> (cal.hours[4:0] == 5'h12) && (cal.hours[5] != $past(cal.hours[5]));
    endproperty
    a_hour12_flip: assert property (p_hour12_flip) else $error("12 hour meridiem flip failed");

    property p_leap_feb;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (hour_carry && !I_REG_WR && cal.month == 8'h02 && cal.day == 8'h28 && cal.year == 8'h04)
        |=> (cal.day == 8'h29) && (cal.month == 8'h02);
    endproperty
    a_leap_feb: assert property (p_leap_feb) else $error("Leap February lost its 29th");

    property p_weekday_wrap;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (hour_carry && !I_REG_WR && cal.weekday == 8'h06) |=> cal.weekday == 8'h00 ##1 !O_NEW_WEEK;
    endproperty
    a_weekday_wrap: assert property (p_weekday_wrap) else $error("Weekday did not wrap");

    property p_month_wrap;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (day_carry && !I_REG_WR && cal.month == 8'h12)
        |=> (cal.month == 8'h01) && (cal.year != $past(cal.year));
    endproperty
    a_month_wrap: assert property (p_month_wrap) else $error("Month did not wrap into year");

    property p_year_wrap;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (month_carry && !I_REG_WR && cal.year == 8'h99) |=> cal.year == 8'h00;
    endproperty
    a_year_wrap: assert property (p_year_wrap) else $error("Year did not wrap");

    property p_unused_zero;
        @(posedge I_SYS_CLK) disable iff (!I_NRST)
        (I_REG_RD && I_REG_ADDR == 8'h06) |=> O_REG_RDATA[7:3] == 5'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("Unassigned weekday bits not zero");

endmodule

// ### test/rtc_host_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes requests start after reset release; one strobe per two cycles.
module rtc_host_model (
    // Clock and read-back
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    // Request
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // Released lines show the inverse, so a stale value cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule

// ### test/bcd_time_calendar_counters_tb.sv
// Self-checking bench for the time and calendar counter bank.
// Assumes a shortened tick so each scenario fits between two ticks.
module bcd_time_calendar_counters_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned TICKS = 32;
    logic               sys_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               hour_12 = 1'b0;
    logic               wr;
    logic               rd;
    logic [7:0]         addr;
    logic [7:0]         wdata;
    logic [7:0]         rdata;
    logic [7:0]         got;
    rtc_pkg::calendar_t now;
    logic               flag;
    logic               tick;
    logic               week;
    int                 bad_count = 0;
    int                 compares = 0;

    always #5 sys_clk = ~sys_clk;

    rtc_calendar #(.TICK_CYCLES(TICKS)) uut (
        .I_SYS_CLK(sys_clk), .I_NRST(nrst), .I_HOUR_12(hour_12),
        .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .O_REG_RDATA(rdata), .O_TIME(now), .O_RESET_OCCURRED_FLAG(flag),
        .O_SECOND_TICK(tick), .O_NEW_WEEK(week)
    );

    rtc_host_model host (
        .i_clk(sys_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata)
    );

    task automatic chk(input string what, input logic [55:0] seen, input logic [55:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Returns just after the edge that applied a tick
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 100);
        if (n >= 100) chk("tick", 56'h0, 56'h1);
        @(posedge sys_clk);
        #1;
    endtask

    // Loads 59:59 and a date, then checks the state after one tick
    task automatic roll(input logic h12, input logic [7:0] hr, dy, wd, mo, yr, input logic [55:0] exp);
        wait_tick();
        @(posedge sys_clk);
        hour_12 <= h12;
        host.wr(rtc_pkg::ADDR_SECONDS, 8'h59);
        host.wr(rtc_pkg::ADDR_MINUTES, 8'h59);
        host.wr(rtc_pkg::ADDR_HOURS, hr);
        host.wr(rtc_pkg::ADDR_DAY, dy);
        host.wr(rtc_pkg::ADDR_WEEKDAY, wd);
        host.wr(rtc_pkg::ADDR_MONTH, mo);
        host.wr(rtc_pkg::ADDR_YEAR, yr);
        wait_tick();
        chk("time", now, exp);
    endtask

    // Checks the flag, the counters and a read-back just after a reset release
    task automatic after_reset();
        chk("flag", flag, 1'b1);
        chk("reset time", now, {8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
        host.rd(rtc_pkg::ADDR_SECONDS, got);
        chk("rd seconds", got, 8'h80);
    endtask

    // Unmapped address ignores a write and reads zero; weekday high bits read zero
    task automatic unmapped();
        host.wr(8'h0a, 8'h5a);
        host.rd(8'h0a, got);
        chk("rd unmapped", got, 8'h00);
        host.rd(rtc_pkg::ADDR_WEEKDAY, got);
        chk("rd weekday", got, 8'h00);
    endtask

    // A second reset in mid-run must raise the flag again and reload the counters
    task automatic mid_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        after_reset();
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        after_reset();
        unmapped();
        roll(0, 8'he3, 8'h28, 8'hfe, 8'h02, 8'h01, {8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h01});
        chk("new week", week, 1'b0);
        chk("flag cleared", flag, 1'b0);
        host.rd(rtc_pkg::ADDR_SECONDS, got);
        chk("rd seconds", got, 8'h00);
        roll(0, 8'h23, 8'h28, 8'h00, 8'h02, 8'h04, {8'h00, 8'h00, 8'h00, 8'h29, 8'h01, 8'h02, 8'h04});
        chk("new week", week, 1'b1);
        roll(0, 8'h23, 8'h29, 8'h06, 8'h02, 8'h00, {8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00});
        roll(0, 8'h23, 8'h31, 8'h03, 8'h12, 8'h99, {8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00});
        roll(0, 8'h09, 8'h30, 8'h02, 8'h04, 8'h07, {8'h00, 8'h00, 8'h10, 8'h30, 8'h02, 8'h04, 8'h07});
        roll(1, 8'h31, 8'h30, 8'h02, 8'h04, 8'h07, {8'h00, 8'h00, 8'h12, 8'h01, 8'h03, 8'h05, 8'h07});
        roll(1, 8'h11, 8'h15, 8'h05, 8'h06, 8'h07, {8'h00, 8'h00, 8'h32, 8'h15, 8'h05, 8'h06, 8'h07});
        host.rd(rtc_pkg::ADDR_MINUTES, got);
        chk("rd minutes", got, 8'h00);
        mid_reset();
        stop_test();
    end

    // Whole run is under a thousand cycles; this only cuts a hang
    initial begin
        #50us;
        bad_count++;
        stop_test();
    end
endmodule
